// *** core/uvwcg_hys.sv ***
// position hysteresis filter ahead of the commutation decoder
// assumes the position input is a wrapping binary count of one revolution
module uvwcg_hys
  import uvwcg_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [POS_W-1:0] pos_in,
  output logic      [POS_W-1:0] pos_out
);
  logic [POS_W-1:0] held_q, held_d;
  logic             up_q, up_d;
  logic [POS_W-1:0] delta;
  logic [POS_W-1:0] mag_back;

  // ==========================================================================
  // follow in the running direction, reverse only past the hysteresis
  always_comb begin
    held_d   = held_q;
    up_d     = up_q;
    delta    = pos_in - held_q;
    mag_back = held_q - pos_in;
    if (delta != '0 && !delta[POS_W-1]) begin
      if (up_q || delta > HYS_STEPS) begin
        held_d = pos_in;
        up_d   = 1'b1;
      end
    end else if (delta[POS_W-1]) begin
      if (!up_q || mag_back > HYS_STEPS) begin
        held_d = pos_in;
        up_d   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      held_q <= RST_ANGLE;
      up_q   <= 1'b1;
    end else begin
      held_q <= held_d;
      up_q   <= up_d;
    end
  end

  assign pos_out = held_q;

  // ==========================================================================
  // a one-step reversal never moves the held position
  a_hys_reverse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (up_q && pos_in == held_q - HYS_STEPS) |=> $stable(held_q))
    else $error("one-step reversal passed the hysteresis");
endmodule // uvwcg_hys

// *** core/uvwcg_top.sv ***
// three-phase commutation generator with its serial register file
// assumes single-cycle register strobes and a position updated on clk_in
module uvwcg_top
  import uvwcg_pkg::*;
#(
  parameter int PAIR_LIMIT = 16
)(
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic [uvwcg_pkg::ADR_W-1:0] reg_addr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [uvwcg_pkg::POS_W-1:0] abs_position_in,
  input  wire logic [uvwcg_pkg::POS_W-1:0] nonius_period_in,
  input  wire logic [uvwcg_pkg::POS_W-1:0] multiturn_data_in,
  input  wire logic                       multiturn_enable_in,
  input  wire logic                       warm_restart_cmd_in,
  input  wire logic                       absolute_recompute_command_in,
  output logic      [7:0]                 reg_rdata_out,
  output logic      [2:0]                 commutation_outputs_out,
  output logic      [2:0]                 second_port_out
);
  // refuse pair limits outside the supported range of one to sixteen pairs
  if (PAIR_LIMIT < 1 || PAIR_LIMIT > 16) begin : g_bad_pair_limit
    $error("PAIR_LIMIT must be 1..16");
  end

  // ==========================================================================
  // configuration and working offset state
  logic [2:0]       second_port_mode_q, second_port_mode_d;
  logic             direction_invert_q, direction_invert_d;
  logic             sixty_degree_select_q, sixty_degree_select_d;
  logic [5:0]       commutation_pole_pairs_q, commutation_pole_pairs_d;
  logic [POS_W-1:0] start_angle_q, start_angle_d;
  logic [POS_W-1:0] work_off_q, work_off_d;
  logic             startup_q, startup_d;
  logic             load_now;
  logic [7:0]       rdata_d;

  // pole code to pair count, floored and clamped to the supported range
  function automatic logic [4:0] pairs_of(input logic [5:0] code);
    logic [6:0] p;
    p = ({1'b0, code} + 7'h01) / 7'h03;
    if (p < 7'h01) p = 7'h01;
    if (p > 7'(PAIR_LIMIT)) p = 7'(PAIR_LIMIT);
    return p[4:0];
  endfunction

  // register read decode, reserved bits read zero
  function automatic logic [7:0] read_of(input logic [ADR_W-1:0] a);
    case (a)
      ADR_PORT_MODE:  read_of = {second_port_mode_q, 5'h00};
      ADR_DIR_CFG:    read_of = {direction_invert_q, 7'h00};
      ADR_SHAPE_CFG:  read_of = {4'h0, sixty_degree_select_q, 3'h0};
      ADR_POLE_CFG:   read_of = {2'h0, commutation_pole_pairs_q};
      ADR_WOFF_LOW:   read_of = {work_off_q[3:0], 4'h0};
      ADR_WOFF_HIGH:  read_of = work_off_q[11:4];
      ADR_START_LOW:  read_of = {start_angle_q[3:0], 4'h0};
      ADR_START_HIGH: read_of = start_angle_q[11:4];
      default:        read_of = 8'h00;
    endcase
  endfunction

  assign load_now = startup_q | warm_restart_cmd_in | absolute_recompute_command_in;

  // ==========================================================================
  // register writes, read data and working offset computation
  always_comb begin
    second_port_mode_d       = second_port_mode_q;
    direction_invert_d       = direction_invert_q;
    sixty_degree_select_d    = sixty_degree_select_q;
    commutation_pole_pairs_d = commutation_pole_pairs_q;
    start_angle_d            = start_angle_q;
    work_off_d               = work_off_q;
    startup_d                = 1'b0;
    rdata_d                  = reg_rdata_out;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADR_PORT_MODE:  second_port_mode_d = reg_wdata_in[MODE_LSB+:3];
        ADR_DIR_CFG:    direction_invert_d = reg_wdata_in[DIR_BIT];
        ADR_SHAPE_CFG:  sixty_degree_select_d = reg_wdata_in[SEL60_BIT];
        ADR_POLE_CFG:   commutation_pole_pairs_d = reg_wdata_in[POLE_MSB:0];
        ADR_START_LOW:  start_angle_d[3:0] = reg_wdata_in[NIB_LSB+:4];
        ADR_START_HIGH: start_angle_d[11:4] = reg_wdata_in;
        default:        start_angle_d = start_angle_q; // working offset is read-only
      endcase
    end
    if (load_now) begin
      // start angle amended by nonius and optional multiturn data
      work_off_d = start_angle_q + nonius_period_in
                   + (multiturn_enable_in ? multiturn_data_in : RST_ANGLE);
    end
    if (reg_rd_in) begin
      rdata_d = read_of(reg_addr_in);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      second_port_mode_q       <= RST_MODE;
      direction_invert_q       <= 1'b0;
      sixty_degree_select_q    <= 1'b0;
      commutation_pole_pairs_q <= RST_POLE_CODE;
      start_angle_q            <= RST_ANGLE;
      work_off_q               <= RST_ANGLE;
      startup_q                <= 1'b1;
      reg_rdata_out            <= 8'h00;
    end else begin
      second_port_mode_q       <= second_port_mode_d;
      direction_invert_q       <= direction_invert_d;
      sixty_degree_select_q    <= sixty_degree_select_d;
      commutation_pole_pairs_q <= commutation_pole_pairs_d;
      start_angle_q            <= start_angle_d;
      work_off_q               <= work_off_d;
      startup_q                <= startup_d;
      reg_rdata_out            <= rdata_d;
    end
  end

  // ==========================================================================
  // direction, hysteresis and electrical angle
  logic [POS_W-1:0] dir_pos;
  logic [POS_W-1:0] held_pos;
  logic [POS_W-1:0] mech_rel;
  logic [16:0]      elec_prod;
  logic [POS_W-1:0] elec;
  logic [4:0]       pairs;

  assign dir_pos = direction_invert_q ? POS_W'(-abs_position_in) : abs_position_in;

  uvwcg_hys u_hys (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pos_in     (dir_pos),
    .pos_out    (held_pos)
  );

  assign pairs     = pairs_of(commutation_pole_pairs_q);
  assign mech_rel  = held_pos - work_off_q;
  assign elec_prod = mech_rel * pairs;
  assign elec      = elec_prod[POS_W-1:0]; // one cycle per pole pair

  // ==========================================================================
  // decode outputs from the electrical angle, bit 0 first phase
  logic [2:0] uvw_q, uvw_d;
  logic [2:0] port_q, port_d;

  always_comb begin
    uvw_d[0] = elec < DEG180;
    if (sixty_degree_select_q) begin
      uvw_d[1] = elec >= DEG60 && elec < DEG240;
      uvw_d[2] = elec >= DEG120 && elec < DEG300;
    end else begin
      uvw_d[1] = elec >= DEG120 && elec < DEG300;
      uvw_d[2] = elec >= DEG240 || elec < DEG60;
    end
    port_d = (second_port_mode_q == MODE_COMMUTATION) ? uvw_d : 3'h0;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      uvw_q  <= 3'h0;
      port_q <= 3'h0;
    end else begin
      uvw_q  <= uvw_d;
      port_q <= port_d;
    end
  end

  assign commutation_outputs_out = uvw_q;
  assign second_port_out         = port_q;

  // ==========================================================================
  // checks
  a_port_route: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (second_port_mode_q != MODE_COMMUTATION) |=> (second_port_out == 3'h0))
    else $error("second port driven outside commutation mode");
  a_port_match: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (second_port_mode_q == MODE_COMMUTATION) |=> (second_port_out == commutation_outputs_out))
    else $error("second port differs from commutation outputs");
  a_pair_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pairs >= 5'h01 && pairs <= MAX_PAIRS)
    else $error("pair count out of range");
  a_spacing_120: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sixty_degree_select_q |-> (uvw_d != 3'h0 && uvw_d != 3'h7))
    else $error("120 degree pattern produced all-equal state");
  a_pole_decode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && reg_addr_in == ADR_POLE_CFG && reg_wdata_in[5:0] == 6'h2f)
    |=> (pairs == MAX_PAIRS))
    else $error("code 0x2f did not give sixteen pairs");
  a_spacing_60: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sixty_degree_select_q && elec < DEG60) |-> (uvw_d == 3'h1))
    else $error("60 degree pattern wrong in first sector");
  a_start_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && reg_addr_in == ADR_START_HIGH) |=> (start_angle_q[11:4] == $past(reg_wdata_in)))
    else $error("start angle high byte not stored");
  a_offset_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (absolute_recompute_command_in && !multiturn_enable_in)
    |=> (work_off_q == $past(start_angle_q) + $past(nonius_period_in)))
    else $error("working offset not amended on recompute");
  a_offset_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && reg_addr_in == ADR_WOFF_HIGH && !load_now) |=> $stable(work_off_q))
    else $error("working offset changed by a write");
  a_dir_invert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    direction_invert_q |-> (dir_pos + abs_position_in == '0))
    else $error("inverted position not mirrored");
  a_start_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && reg_addr_in == ADR_START_LOW)
    |=> ({start_angle_q[3:0], 4'h0} == ($past(reg_wdata_in) & 8'hf0)))
    else $error("start angle low nibble not stored");
  a_woff_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !load_now |=> $stable(work_off_q))
    else $error("working offset changed without a load");
  a_woff_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_rd_in && reg_addr_in == ADR_WOFF_HIGH && !load_now)
    |=> (reg_rdata_out == work_off_q[11:4]))
    else $error("working offset high byte read wrong");
  a_first_sector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!sixty_degree_select_q && elec < DEG60) |-> (uvw_d == 3'h5))
    else $error("120 degree pattern wrong in first sector");
  a_pole_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (commutation_pole_pairs_q == 6'h02) |-> (pairs == 5'h01))
    else $error("code 0x02 did not give one pair");
endmodule // uvwcg_top

// *** inc/uvwcg_pkg.sv ***
// constants shared by the commutation generator and its hysteresis filter
// assumes a byte-wide serial register port and a 12-bit singleturn position source
//
// Function
// - second port carries commutation outputs when its mode field equals 0x1.
// - commutation works for one to sixteen pole pairs, repeating once per pair.
// - output switching uses fixed hysteresis of one position step, 0.0879 degrees.
// - default setting shifts the three outputs 120 degrees apart.
// - pole field at 0x17 bits 5:0 holds three times pairs minus one.
// - select bit 3 at 0x16 chooses 120 or 60 degree edge spacing.
// - twelve-bit start angle shifts sequence, one step is 360/4096 degrees.
// - start angle low nibble sits in 0x4B bits 7:4, high byte at 0x4C.
// - startup or restart commands load start angle plus nonius and multiturn data.
// - computed working offset is read-only at 0x23 bits 7:4 and 0x24.
// - direction bit 7 at 0x15 reverses counting direction of the outputs.
package uvwcg_pkg;
  // ==========================================================================
  // widths
  localparam int POS_W = 12;
  localparam int ADR_W = 7;

  // ==========================================================================
  // register addresses
  localparam logic [ADR_W-1:0] ADR_PORT_MODE  = 7'h0b;
  localparam logic [ADR_W-1:0] ADR_DIR_CFG    = 7'h15;
  localparam logic [ADR_W-1:0] ADR_SHAPE_CFG  = 7'h16;
  localparam logic [ADR_W-1:0] ADR_POLE_CFG   = 7'h17;
  localparam logic [ADR_W-1:0] ADR_WOFF_LOW   = 7'h23;
  localparam logic [ADR_W-1:0] ADR_WOFF_HIGH  = 7'h24;
  localparam logic [ADR_W-1:0] ADR_START_LOW  = 7'h4b;
  localparam logic [ADR_W-1:0] ADR_START_HIGH = 7'h4c;

  // ==========================================================================
  // field positions
  localparam int MODE_LSB    = 5;
  localparam int DIR_BIT     = 7;
  localparam int SEL60_BIT   = 3;
  localparam int POLE_MSB    = 5;
  localparam int NIB_LSB     = 4;

  // ==========================================================================
  // codes and reset values
  localparam logic [2:0]       MODE_COMMUTATION = 3'h1;
  localparam logic [2:0]       RST_MODE         = 3'h0;
  localparam logic [5:0]       RST_POLE_CODE    = 6'h02;
  localparam logic [POS_W-1:0] RST_ANGLE        = 12'h000;
  localparam logic [4:0]       MAX_PAIRS        = 5'h10;

  // ==========================================================================
  // angle thresholds within one electrical cycle of 4096 steps
  localparam logic [POS_W-1:0] HYS_STEPS = 12'h001; // 0.0879 deg mechanical
  localparam logic [POS_W-1:0] DEG60     = 12'h2ab;
  localparam logic [POS_W-1:0] DEG120    = 12'h555;
  localparam logic [POS_W-1:0] DEG180    = 12'h800;
  localparam logic [POS_W-1:0] DEG240    = 12'haab;
  localparam logic [POS_W-1:0] DEG300    = 12'hd55;
endpackage

// *** verif/uvw_commutation_generator_test.sv ***
// self-checking bench for the commutation generator and its registers
// assumes the design package and the motor model are compiled first
module uvw_commutation_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uvwcg_pkg::*;
  logic clk_in, sys_rst_in, reg_wr_in, reg_rd_in, mt_en, warm_cmd, recomp_cmd;
  logic [6:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, rdata, steps;
  logic [11:0] pos, nonius, mturn;
  logic [2:0]  uvw, port2;
  int          mismatches, n_checks;
  // ==========================================================================
  // design and motor model
  uvwcg_top uvwcg_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .abs_position_in(pos), .nonius_period_in(nonius), .multiturn_data_in(mturn),
    .multiturn_enable_in(mt_en), .warm_restart_cmd_in(warm_cmd),
    .absolute_recompute_command_in(recomp_cmd), .reg_rdata_out(rdata),
    .commutation_outputs_out(uvw), .second_port_out(port2));
  uvwcg_motor_model uvwcg_motor_model_i (.clk_in(clk_in), .phase_in(uvw),
    .step_count_out(steps));
  // ==========================================================================
  // helpers
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [2:0] exp_uvw(input logic [11:0] e, input logic s60);
    logic u, v, w;
    u = e < DEG180;
    v = s60 ? (e >= DEG60 && e < DEG240) : (e >= DEG120 && e < DEG300);
    w = s60 ? (e >= DEG120 && e < DEG300) : (e >= DEG240 || e < DEG60);
    return {w, v, u};
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge clk_in);
    #1 reg_wr_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge clk_in);
    #1 reg_rd_in = 1'b0;
    @(posedge clk_in);
    #1 chk(12'(rdata), 12'(d));
  endtask
  task automatic pulse(input bit warm);
    if (warm) warm_cmd = 1'b1;
    else recomp_cmd = 1'b1;
    @(posedge clk_in);
    #1 warm_cmd = 1'b0;
    recomp_cmd = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic at_pos(input logic [11:0] p, input logic [11:0] e, input logic s60);
    pos = p;
    repeat (4) @(posedge clk_in);
    #1 chk(12'(uvw), 12'(exp_uvw(e, s60)));
  endtask
  task automatic sectors(input logic s60);
    for (int j = 0; j < 6; j++) at_pos(12'(j * 683 + 64), 12'(j * 683 + 64), s60);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] s0;
    rd_chk(ADR_POLE_CFG, 8'h02);
    rd_chk(ADR_DIR_CFG, 8'h00);
    rd_chk(ADR_SHAPE_CFG, 8'h00);
    rd_chk(7'h7f, 8'h00);
    rd_chk(ADR_WOFF_HIGH, 8'h00);
    s0 = steps;
    sectors(1'b0);
    chk(12'(steps - s0), 12'h005);
  endtask
  task automatic t_rerun();
    wr(ADR_START_HIGH, 8'h12);
    wr(ADR_PORT_MODE, 8'h20);
    nonius = 12'h010;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    chk(12'(port2), 12'h000);
    rd_chk(ADR_WOFF_LOW, 8'h00);
    rd_chk(ADR_WOFF_HIGH, 8'h01);
    rd_chk(ADR_START_HIGH, 8'h00);
    rd_chk(ADR_PORT_MODE, 8'h00);
    at_pos(12'h808, 12'(12'h808 - 12'h010), 1'b0);
  endtask
  task automatic t_poles();
    for (int k = 1; k <= 16; k++) begin
      wr(ADR_POLE_CFG, 8'(3 * k - 1));
      rd_chk(ADR_POLE_CFG, 8'(3 * k - 1));
      at_pos(12'h123, 12'(12'h123 * k), 1'b0);
      at_pos(12'h9a7, 12'(12'h9a7 * k), 1'b0);
    end
    wr(ADR_POLE_CFG, 8'h02);
  endtask
  task automatic t_offset();
    wr(ADR_SHAPE_CFG, 8'h08);
    rd_chk(ADR_SHAPE_CFG, 8'h08);
    sectors(1'b1);
    wr(ADR_SHAPE_CFG, 8'h00);
    wr(ADR_START_LOW, 8'h5a);
    wr(ADR_START_HIGH, 8'h12);
    rd_chk(ADR_START_HIGH, 8'h12);
    nonius = 12'h010;
    mturn = 12'h100;
    mt_en = 1'b1;
    pulse(1'b1);
    rd_chk(ADR_WOFF_LOW, 8'h50);
    rd_chk(ADR_WOFF_HIGH, 8'h23);
    at_pos(12'h400, 12'(12'h400 - 12'h235), 1'b0);
    mt_en = 1'b0;
    pulse(1'b0);
    wr(ADR_WOFF_HIGH, 8'hff);
    rd_chk(ADR_WOFF_HIGH, 8'h13);
    at_pos(12'h500, 12'(12'h500 - 12'h135), 1'b0);
    wr(ADR_START_LOW, 8'h00);
    wr(ADR_START_HIGH, 8'h00);
    nonius = 12'h000;
    pulse(1'b0);
  endtask
  task automatic t_dir_hys_port();
    wr(ADR_DIR_CFG, 8'h80);
    rd_chk(ADR_DIR_CFG, 8'h80);
    at_pos(12'h100, 12'hf00, 1'b0);
    at_pos(12'h600, 12'ha00, 1'b0);
    wr(ADR_DIR_CFG, 8'h00);
    at_pos(12'h7fe, 12'h7fe, 1'b0);
    at_pos(12'h7ff, 12'h7ff, 1'b0);
    at_pos(12'h800, 12'h800, 1'b0);
    at_pos(12'h7ff, 12'h800, 1'b0);
    at_pos(12'h7fe, 12'h7fe, 1'b0);
    wr(ADR_PORT_MODE, 8'h20);
    rd_chk(ADR_PORT_MODE, 8'h20);
    at_pos(12'h900, 12'h900, 1'b0);
    chk(12'(port2), 12'(exp_uvw(12'h900, 1'b0)));
    wr(ADR_PORT_MODE, 8'h40);
    chk(12'(port2), 12'h000);
  endtask
  // ==========================================================================
  // verdict, clock, watchdog and main sequence
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  initial begin
    {reg_wr_in, reg_rd_in, mt_en, warm_cmd, recomp_cmd} = 5'h00;
    reg_addr_in = 7'h00;
    reg_wdata_in = 8'h00;
    {pos, nonius, mturn} = 36'h0;
    sys_rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    t_reset();
    t_poles();
    t_offset();
    t_dir_hys_port();
    t_rerun();
    test_done();
  end
endmodule // uvw_commutation_generator_test

// *** verif/uvwcg_motor_model.sv ***
// motor driver stand-in that counts the commutation steps it receives
// assumes the phase pattern changes only after rising edges of clk_in
module uvwcg_motor_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] phase_in,
  output logic      [7:0] step_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_q;
  // ==========================================================================
  // one step per change of the phase pattern
  initial begin
    step_count_out = 8'h00;
    last_q = 3'h0;
  end
  always @(posedge clk_in) begin
    last_q <= phase_in;
    if (last_q !== phase_in) step_count_out <= step_count_out + 8'h01;
  end
endmodule // uvwcg_motor_model
